// ### rtl/rwcm_pkg.sv
// Constants, register map and carrier types for the reset, watchdog and clock monitor block
`default_nettype none

package rwcm_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_OPTIONS2 = 8'h38;
  localparam logic [7:0] IDX_OPTIONS  = 8'h39;
  localparam logic [7:0] IDX_SERVICE  = 8'h3a;
  localparam logic [7:0] IDX_CAUSE    = 8'h3d;
  localparam logic [7:0] IDX_TEST     = 8'h3e;
  localparam logic [7:0] IDX_CONFIG   = 8'h3f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_WDOG_DIS   = 0;
  localparam int CFG_ROM_SEL    = 1;
  localparam int OPT_RATE_LO    = 0;
  localparam int OPT_RATE_HI    = 1;
  localparam int OPT_FORCE_MONITOR_ENABLE       = 2;
  localparam int OPT_CME        = 3;
  localparam int SYSTEM_OPTIONS_SECOND_PC_WOR    = 0;
  localparam int SYSTEM_OPTIONS_SECOND_STRETCH   = 1;
  localparam int SYSTEM_OPTIONS_SECOND_LIR_DRV   = 2;
  localparam int TEST_DISABLE_RESETS_BIT      = 0;
  localparam int CAUSE_EXT      = 0;
  localparam int CAUSE_WDOG     = 1;
  localparam int CAUSE_CMON     = 2;
  localparam int CAUSE_WIN_OPEN = 3;

  // ----------------------------------------------------------------
  // Values and reset states
  // ----------------------------------------------------------------
  localparam logic [7:0] SVC_ARM     = 8'h55;
  localparam logic [7:0] SVC_CLEAR   = 8'haa;
  localparam logic [1:0] RATE_RESET  = 2'h0;
  localparam logic [7:0] CONFIG_INIT = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 10;
  localparam logic [2:0] DRIVE_CYCLES  = 3'h4;
  localparam logic [2:0] SAMPLE_DELAY  = 3'h2;
  localparam logic [2:0] SYNC_STAGES   = 3'h2;
  localparam logic [6:0] OPT_WINDOW    = 7'h40;
  localparam int         WD_BASE       = 32768;
  localparam int         CM_DELAY_NS   = 50000;
  localparam int         CM_CYCLES     = CM_DELAY_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RS_IDLE, RS_DRIVE, RS_SETTLE, RS_EXT_HOLD} rwcm_rs_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rwcm_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rwcm_wb_rsp_t;

endpackage

`default_nettype wire

// ### rtl/rwcm_top.sv
// Reset pin sequencer, watchdog, clock monitor and option bits behind a Wishbone slave
//
// Functional notes
// - Internal reset drives the reset pin low four cycles, then releases it.
// - Two cycles after release sample pin: low means external, high means internal.
// - Normal modes: watchdog runs from reset; disable bit set turns it off.
// - Special modes: disable-resets bit starts set; software clears it to allow watchdog resets.
// - Configuration register: one write in normal modes, unlimited in special modes.
// - Watchdog timeout is 2^15, 2^17, 2^19 or 2^21 cycles by rate field.
// - Reset clears the rate field, selecting the shortest timeout.
// - Normal modes: protected option bits take one write within 64 cycles of reset.
// - Write 0x55 then 0xaa to the service register to restart the watchdog.
// - Enabled watchdog reaching timeout before service causes a system reset.
// - Enabled clock monitor resets the system when no clock edge comes in time.
// - Monitor enable bit is read/write anytime, one enables, reset clears it.
// - Force bit keeps the monitor enabled until next reset, overriding enable bit.
// - Monitor flags below 10 kHz and never at 200 kHz or faster.
// - Instruction-start output goes low per instruction, high between consecutive ones.
// - Drive bit enables push-pull output; resets to expanded-mode flag; expanded only.
// - Port C wired-OR bit set makes port C outputs open drain.
// - Stretch bit lengthens off-chip accesses in the selected range by one cycle.
`default_nettype none

module rwcm_top #(
  parameter int WD_BASE_CYCLES = rwcm_pkg::WD_BASE,
  parameter int CM_LIMIT       = rwcm_pkg::CM_CYCLES
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RSTN,
  // Register bus
  input  wire rwcm_pkg::rwcm_wb_req_t WB_REQ,
  output var  rwcm_pkg::rwcm_wb_rsp_t WB_RSP,
  // Reset pin and system reset
  input  wire logic                  RESET_PIN_I,
  output logic                       RESET_PIN_O,
  output logic                       RESET_PIN_OE,
  output logic                       SYS_RST_N,
  // Mode straps and monitored clock
  input  wire logic                  MODE_SPECIAL,
  input  wire logic                  MODE_EXPANDED,
  input  wire logic                  MON_CLK,
  // Instruction-start pin
  input  wire logic                  INSTR_START,
  output logic                       LIR_O,
  output logic                       LIR_OE,
  // Port C
  input  wire logic [7:0]            PORTC_DATA,
  input  wire logic [7:0]            PORTC_DIR,
  output logic      [7:0]            PORTC_O,
  output logic      [7:0]            PORTC_OE,
  // External access stretch
  input  wire logic                  EXT_ACC,
  input  wire logic                  EXT_ACC_HI,
  output logic                       E_STRETCH
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                     pin_s1;
    logic                     pin_s2;
    logic                     mclk_s1;
    logic                     mclk_s2;
    logic                     mclk_s3;
    logic [1:0]               mode_s1;
    logic [1:0]               mode_s2;
    logic                     mode_done;
    logic                     special;
    logic                     expanded;
    logic                     wdog_dis;
    logic                     rom_sel;
    logic                     cfg_written;
    logic [1:0]               rate;
    logic                     force_monitor_enable;
    logic                     clock_monitor_enable;
    logic                     opt_written;
    logic                     pc_wor;
    logic                     stretch_en;
    logic                     lir_drv;
    logic                     disable_resets_bit;
    logic [6:0]               win_cnt;
    logic                     svc_armed;
    logic [22:0]              wd_cnt;
    logic [15:0]              cm_cnt;
    rwcm_pkg::rwcm_rs_state_t rs_state;
    logic [2:0]               rs_cnt;
    logic [1:0]               pend_cause;
    logic [2:0]               cause;
    logic                     ack;
    logic [7:0]               rdat;
    logic                     pin_oe;
    logic                     sys_rst_n;
    logic                     lir_o;
    logic                     lir_pend;
    logic                     lir_oe;
    logic [7:0]               pc_o;
    logic [7:0]               pc_oe;
    logic                     e_stretch;
  } rwcm_state_t;

  rwcm_state_t st_reg;
  rwcm_state_t st_next;
  logic        rst_s1_reg;
  logic        rst_n;

  // ----------------------------------------------------------------
  // Reset release synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic        in_reset;
  logic        wd_enable;
  logic        cm_active;
  logic        cm_edge;
  logic        wd_trig;
  logic        cm_trig;
  logic [22:0] wd_limit;
  logic        wr;
  logic        rd_req;
  logic        win_open;
  logic [7:0]  wdat;

  always_comb begin
    in_reset  = st_reg.rs_state != rwcm_pkg::RS_IDLE;
    wd_enable = st_reg.mode_done & ~st_reg.wdog_dis & ~(st_reg.special & st_reg.disable_resets_bit);
    cm_active = st_reg.clock_monitor_enable | st_reg.force_monitor_enable;
    cm_edge   = st_reg.mclk_s2 ^ st_reg.mclk_s3;
    // Shift by twice the rate: 2^15, 2^17, 2^19, 2^21
    wd_limit  = 23'(WD_BASE_CYCLES) << {st_reg.rate, 1'b0};
    wd_trig   = wd_enable & (st_reg.wd_cnt == wd_limit - 23'h1);
    cm_trig   = cm_active & (st_reg.cm_cnt == 16'(CM_LIMIT - 1));
    rd_req    = WB_REQ.cyc & WB_REQ.stb & ~st_reg.ack;
    // Write lands on the edge where the master sees ack
    wr        = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & WB_REQ.sel[0] & st_reg.ack & ~in_reset;
    wdat      = WB_REQ.dat[7:0];
    win_open  = st_reg.special | (~st_reg.opt_written & (st_reg.win_cnt < rwcm_pkg::OPT_WINDOW));
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // Pin synchronisers
    st_next.pin_s1  = RESET_PIN_I;
    st_next.pin_s2  = st_reg.pin_s1;
    st_next.mclk_s1 = MON_CLK;
    st_next.mclk_s2 = st_reg.mclk_s1;
    st_next.mclk_s3 = st_reg.mclk_s2;
    st_next.mode_s1 = {MODE_EXPANDED, MODE_SPECIAL};
    st_next.mode_s2 = st_reg.mode_s1;

    // Straps caught once the synchroniser holds a settled value
    if (!st_reg.mode_done && st_reg.win_cnt == 7'(rwcm_pkg::SYNC_STAGES)) begin
      st_next.mode_done = 1'b1;
      st_next.special   = st_reg.mode_s2[0];
      st_next.expanded  = st_reg.mode_s2[1];
      st_next.disable_resets_bit      = st_reg.mode_s2[0];
      st_next.lir_drv   = st_reg.mode_s2[1];
    end

    if (st_reg.win_cnt != rwcm_pkg::OPT_WINDOW) begin
      st_next.win_cnt = st_reg.win_cnt + 7'h1;
    end

    // Watchdog counter
    if (!wd_enable || wd_trig) begin
      st_next.wd_cnt = '0;
    end else begin
      st_next.wd_cnt = st_reg.wd_cnt + 23'h1;
    end

    // Clock monitor: cycles since last monitored edge
    if (!cm_active || cm_edge || cm_trig) begin
      st_next.cm_cnt = '0;
    end else begin
      st_next.cm_cnt = st_reg.cm_cnt + 16'h1;
    end

    // Bus slave
    st_next.ack = rd_req;
    if (rd_req) begin
      unique case (WB_REQ.adr)
        rwcm_pkg::IDX_CONFIG:   st_next.rdat = {6'h00, st_reg.rom_sel, st_reg.wdog_dis};
        rwcm_pkg::IDX_OPTIONS:  st_next.rdat = {4'h0, st_reg.clock_monitor_enable, st_reg.force_monitor_enable, st_reg.rate};
        rwcm_pkg::IDX_OPTIONS2: st_next.rdat = {5'h00, st_reg.lir_drv, st_reg.stretch_en, st_reg.pc_wor};
        rwcm_pkg::IDX_TEST:     st_next.rdat = {7'h00, st_reg.disable_resets_bit};
        rwcm_pkg::IDX_CAUSE:    st_next.rdat = {4'h0, win_open, st_reg.cause};
        default:                st_next.rdat = 8'h00;
      endcase
    end

    if (wr) begin
      unique case (WB_REQ.adr)
        rwcm_pkg::IDX_CONFIG: begin
          if (st_reg.special || !st_reg.cfg_written) begin
            st_next.wdog_dis    = wdat[rwcm_pkg::CFG_WDOG_DIS];
            st_next.rom_sel     = wdat[rwcm_pkg::CFG_ROM_SEL];
            st_next.cfg_written = 1'b1;
          end
        end
        rwcm_pkg::IDX_OPTIONS: begin
          st_next.clock_monitor_enable = wdat[rwcm_pkg::OPT_CME];
          if (win_open) begin
            st_next.rate        = wdat[rwcm_pkg::OPT_RATE_HI:rwcm_pkg::OPT_RATE_LO];
            st_next.opt_written = 1'b1;
          end
          // Force can only be raised; it falls only at the next reset
          if (wdat[rwcm_pkg::OPT_FORCE_MONITOR_ENABLE]) begin
            st_next.force_monitor_enable = 1'b1;
          end
        end
        rwcm_pkg::IDX_OPTIONS2: begin
          st_next.pc_wor     = wdat[rwcm_pkg::SYSTEM_OPTIONS_SECOND_PC_WOR];
          st_next.stretch_en = wdat[rwcm_pkg::SYSTEM_OPTIONS_SECOND_STRETCH];
          st_next.lir_drv    = wdat[rwcm_pkg::SYSTEM_OPTIONS_SECOND_LIR_DRV];
        end
        rwcm_pkg::IDX_TEST: begin
          if (st_reg.special) begin
            st_next.disable_resets_bit = wdat[rwcm_pkg::TEST_DISABLE_RESETS_BIT];
          end
        end
        rwcm_pkg::IDX_SERVICE: begin
          if (wdat == rwcm_pkg::SVC_ARM) begin
            st_next.svc_armed = 1'b1;
          end else if (wdat == rwcm_pkg::SVC_CLEAR && st_reg.svc_armed) begin
            st_next.svc_armed = 1'b0;
            st_next.wd_cnt    = '0;
          end
        end
        default: begin
        end
      endcase
    end

    // Reset sequencer
    st_next.rs_cnt = st_reg.rs_cnt + 3'h1;
    unique case (st_reg.rs_state)
      rwcm_pkg::RS_IDLE: begin
        st_next.rs_cnt = '0;
        if (!st_reg.pin_s2) begin
          st_next.rs_state = rwcm_pkg::RS_EXT_HOLD;
          st_next.cause    = 3'h1 << rwcm_pkg::CAUSE_EXT;
        end else if (cm_trig || wd_trig) begin
          st_next.rs_state   = rwcm_pkg::RS_DRIVE;
          st_next.pend_cause = {cm_trig, ~cm_trig};
        end
      end
      rwcm_pkg::RS_DRIVE: begin
        if (st_reg.rs_cnt == rwcm_pkg::DRIVE_CYCLES - 3'h1) begin
          st_next.rs_state = rwcm_pkg::RS_SETTLE;
          st_next.rs_cnt   = '0;
        end
      end
      rwcm_pkg::RS_SETTLE: begin
        // Synchroniser delay added so the sample reflects the pin two cycles after release
        if (st_reg.rs_cnt == rwcm_pkg::SAMPLE_DELAY + rwcm_pkg::SYNC_STAGES - 3'h1) begin
          if (!st_reg.pin_s2) begin
            st_next.rs_state = rwcm_pkg::RS_EXT_HOLD;
            st_next.cause    = 3'h1 << rwcm_pkg::CAUSE_EXT;
          end else begin
            st_next.rs_state = rwcm_pkg::RS_IDLE;
            st_next.cause    = {st_reg.pend_cause, 1'b0};
          end
        end
      end
      rwcm_pkg::RS_EXT_HOLD: begin
        if (st_reg.pin_s2) begin
          st_next.rs_state = rwcm_pkg::RS_IDLE;
        end
      end
    endcase
    st_next.pin_oe    = st_next.rs_state == rwcm_pkg::RS_DRIVE;
    st_next.sys_rst_n = st_next.rs_state == rwcm_pkg::RS_IDLE;

    // System reset returns the block to its reset state; config and cause survive
    if (in_reset) begin
      st_next.rate        = rwcm_pkg::RATE_RESET;
      st_next.clock_monitor_enable         = 1'b0;
      st_next.force_monitor_enable        = 1'b0;
      st_next.svc_armed   = 1'b0;
      st_next.wd_cnt      = '0;
      st_next.cm_cnt      = '0;
      st_next.win_cnt     = '0;
      st_next.opt_written = 1'b0;
      st_next.cfg_written = 1'b0;
      st_next.pc_wor      = 1'b0;
      st_next.stretch_en  = 1'b0;
      st_next.mode_done   = 1'b0;
    end

    // Instruction start: one low cycle, forced high cycle between back-to-back starts
    st_next.lir_o    = 1'b1;
    st_next.lir_pend = 1'b0;
    if (INSTR_START && !st_reg.lir_o) begin
      st_next.lir_pend = 1'b1;
    end else if (INSTR_START || st_reg.lir_pend) begin
      st_next.lir_o = 1'b0;
    end
    st_next.lir_oe = st_reg.lir_drv & st_reg.expanded;

    // Port C drive
    st_next.pc_o  = st_reg.pc_wor ? 8'h00 : PORTC_DATA;
    st_next.pc_oe = st_reg.pc_wor ? (PORTC_DIR & ~PORTC_DATA) : PORTC_DIR;

    // One extra E cycle for off-chip accesses in the selected range
    st_next.e_stretch = st_reg.stretch_en & st_reg.expanded & EXT_ACC & (EXT_ACC_HI == st_reg.rom_sel);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_reg             <= '0;
      st_reg.pin_s1      <= 1'b1;
      st_reg.pin_s2      <= 1'b1;
      st_reg.wdog_dis    <= rwcm_pkg::CONFIG_INIT[rwcm_pkg::CFG_WDOG_DIS];
      st_reg.rom_sel     <= rwcm_pkg::CONFIG_INIT[rwcm_pkg::CFG_ROM_SEL];
      st_reg.rs_state    <= rwcm_pkg::RS_IDLE;
      st_reg.sys_rst_n   <= 1'b1;
      st_reg.lir_o       <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign WB_RSP       = '{ack: st_reg.ack, dat: {24'h000000, st_reg.rdat}};
  assign RESET_PIN_O  = 1'b0;
  assign RESET_PIN_OE = st_reg.pin_oe;
  assign SYS_RST_N    = st_reg.sys_rst_n;
  assign LIR_O        = st_reg.lir_o;
  assign LIR_OE       = st_reg.lir_oe;
  assign PORTC_O      = st_reg.pc_o;
  assign PORTC_OE     = st_reg.pc_oe;
  assign E_STRETCH    = st_reg.e_stretch;

endmodule

`default_nettype wire

// ### test/rwcm_pin_model.sv
// Behavioural model of the external reset circuit sharing the open reset pin
`default_nettype none

module rwcm_pin_model (
  // Clock and device side
  input  wire logic       clk,
  input  wire logic       dev_oe,
  // Bench controls
  input  wire logic       ext_pull,
  input  wire logic [7:0] hold_len,
  // Wired pin level
  output logic            pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] hold_cnt;

  initial hold_cnt = 8'h00;

  // Slow supervisor keeps the pin low past the device release
  always @(posedge clk) begin
    if (dev_oe) begin
      hold_cnt <= hold_len;
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
  end

  // Pull-up wins only once every party has let go
  assign pin_lvl = !(dev_oe || ext_pull || hold_cnt != 8'h00);
endmodule

`default_nettype wire

// ### test/rwcm_top_chk.sv
// Port-level assertions for the reset, watchdog and clock monitor block
`default_nettype none

module rwcm_top_chk #(
  parameter int WD_BASE_CYCLES = 32768,
  parameter int CM_LIMIT       = 5000
) (
  input wire logic       CLK,
  input wire logic       RSTN,
  input wire logic       RESET_PIN_I,
  input wire logic       RESET_PIN_O,
  input wire logic       RESET_PIN_OE,
  input wire logic       SYS_RST_N,
  input wire logic       MODE_EXPANDED,
  input wire logic       INSTR_START,
  input wire logic       LIR_O,
  input wire logic       LIR_OE,
  input wire logic [7:0] PORTC_DATA,
  input wire logic [7:0] PORTC_DIR,
  input wire logic [7:0] PORTC_O,
  input wire logic [7:0] PORTC_OE,
  input wire logic       EXT_ACC,
  input wire logic       E_STRETCH
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // ----------------------------------------------------------------
  // Reset pin
  // ----------------------------------------------------------------
  AST_PIN_DRIVE_FOUR: assert property ($rose(RESET_PIN_OE) |-> RESET_PIN_OE[*4] ##1 !RESET_PIN_OE)
    else $error("reset pin drive not four cycles");
  AST_PIN_LOW_ONLY: assert property (RESET_PIN_OE |-> !RESET_PIN_O && !SYS_RST_N)
    else $error("pin driven without holding system reset");
  AST_INT_RELEASE: assert property ($fell(RESET_PIN_OE) ##0 RESET_PIN_I[*8] |-> ##2 SYS_RST_N)
    else $error("internal reset not released with pin high");
  AST_EXT_HOLD: assert property ((!RESET_PIN_I)[*6] |-> !SYS_RST_N)
    else $error("system reset released while pin held low");

  // ----------------------------------------------------------------
  // Instruction start, port C and stretch
  // ----------------------------------------------------------------
  AST_LIR_PULSE: assert property (INSTR_START && LIR_O ##1 !INSTR_START |-> !LIR_O ##1 LIR_O)
    else $error("instruction start not low for one cycle");
  AST_LIR_BACK: assert property (INSTR_START && !LIR_O |=> LIR_O ##1 !LIR_O)
    else $error("no high gap between consecutive starts");
  AST_LIR_SINGLE: assert property (!MODE_EXPANDED |-> !LIR_OE)
    else $error("instruction start driven in single-chip mode");
  AST_PC_DIR: assert property ((PORTC_OE & ~$past(PORTC_DIR)) == 8'h00)
    else $error("port C drives an input bit");
  AST_PC_DATA: assert property ((PORTC_O & PORTC_OE) == ($past(PORTC_DATA) & PORTC_OE))
    else $error("port C drives wrong level");
  AST_STRETCH_CAUSE: assert property (E_STRETCH |-> $past(EXT_ACC))
    else $error("stretch without external access");

  cover property ($rose(RESET_PIN_OE));
  cover property (E_STRETCH);
  cover property (INSTR_START && !LIR_O);
endmodule

bind rwcm_top rwcm_top_chk #(.WD_BASE_CYCLES(WD_BASE_CYCLES), .CM_LIMIT(CM_LIMIT)) chk_u (
  .CLK(CLK), .RSTN(RSTN), .RESET_PIN_I(RESET_PIN_I), .RESET_PIN_O(RESET_PIN_O),
  .RESET_PIN_OE(RESET_PIN_OE), .SYS_RST_N(SYS_RST_N), .MODE_EXPANDED(MODE_EXPANDED),
  .INSTR_START(INSTR_START), .LIR_O(LIR_O), .LIR_OE(LIR_OE), .PORTC_DATA(PORTC_DATA),
  .PORTC_DIR(PORTC_DIR), .PORTC_O(PORTC_O), .PORTC_OE(PORTC_OE), .EXT_ACC(EXT_ACC),
  .E_STRETCH(E_STRETCH));

`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the reset, watchdog and clock monitor block
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Short counts keep every timeout reachable in simulation
  localparam int WDB = 128;
  localparam int CML = 20;

  logic                   CLK, RSTN, pin_i, pin_oe, sys_rst_n, mon_clk, mon_run;
  logic                   instr_start, lir_o, ext_acc, ext_hi, e_stretch, ext_pull, mode_sp, mode_ex;
  logic [1:0]             mcnt;
  logic [7:0]             pc_data, pc_dir, pc_oe, hold_len, rd;
  rwcm_pkg::rwcm_wb_req_t wb_req;
  rwcm_pkg::rwcm_wb_rsp_t wb_rsp;
  int                     n_mismatch, tests_run, n;

  rwcm_top #(.WD_BASE_CYCLES(WDB), .CM_LIMIT(CML)) dut_u (
    .CLK(CLK), .RSTN(RSTN), .WB_REQ(wb_req), .WB_RSP(wb_rsp), .RESET_PIN_I(pin_i),
    .RESET_PIN_O(), .RESET_PIN_OE(pin_oe), .SYS_RST_N(sys_rst_n), .MODE_SPECIAL(mode_sp),
    .MODE_EXPANDED(mode_ex), .MON_CLK(mon_clk), .INSTR_START(instr_start), .LIR_O(lir_o),
    .LIR_OE(), .PORTC_DATA(pc_data), .PORTC_DIR(pc_dir), .PORTC_O(), .PORTC_OE(pc_oe),
    .EXT_ACC(ext_acc), .EXT_ACC_HI(ext_hi), .E_STRETCH(e_stretch));

  rwcm_pin_model pin_u (.clk(CLK), .dev_oe(pin_oe), .ext_pull(ext_pull), .hold_len(hold_len), .pin_lvl(pin_i));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Monitored clock: one edge every four cycles while running
  always @(posedge CLK) begin
    mcnt <= mcnt + 2'h1;
    if (mon_run && mcnt == 2'h0) mon_clk <= ~mon_clk;
  end

  // ----------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge CLK);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: idx, sel: 4'h1, dat: {24'h0, wd}};
    @(posedge CLK);
    while (wb_rsp.ack !== 1'b1) begin
      @(posedge CLK);
    end
    rd = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    `CHK(rd & m, exp)
  endtask

  // Count cycles until system reset, then wait out reset and strap capture
  task automatic wait_rst(output int cyc);
    int k;
    cyc = 0;
    k = 0;
    while (sys_rst_n !== 1'b0 && cyc < 40000) begin
      @(posedge CLK);
      cyc++;
    end
    while (sys_rst_n !== 1'b1 && k < 2000) begin
      @(posedge CLK);
      k++;
    end
    if (cyc >= 40000 || k >= 2000) n_mismatch++;
    repeat (8) @(posedge CLK);
  endtask

  task automatic pulse_acc(input logic hi, input logic exp);
    @(posedge CLK);
    ext_hi  <= hi;
    ext_acc <= 1'b1;
    @(posedge CLK);
    ext_acc <= 1'b0;
    #1;
    `CHK(e_stretch, exp)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rchk(rwcm_pkg::IDX_OPTIONS, 8'hff, 8'h00);
    rchk(rwcm_pkg::IDX_OPTIONS2, 8'h07, 8'h00);
    rchk(rwcm_pkg::IDX_SERVICE, 8'hff, 8'h00);
    rchk(rwcm_pkg::IDX_CONFIG, 8'h03, 8'h00);
  endtask

  // Every rate code, second rate write refused, service with a stray value between
  task automatic t_watchdog;
    int lim;
    for (int r = 0; r < 4; r++) begin
      lim = WDB << (2 * r);
      rchk(rwcm_pkg::IDX_OPTIONS, 8'h03, 8'h00);
      wb(1'b1, rwcm_pkg::IDX_OPTIONS, 8'(r));
      rchk(rwcm_pkg::IDX_OPTIONS, 8'h03, 8'(r));
      wb(1'b1, rwcm_pkg::IDX_OPTIONS, 8'(r ^ 3));
      rchk(rwcm_pkg::IDX_OPTIONS, 8'h03, 8'(r));
      wb(1'b1, rwcm_pkg::IDX_SERVICE, rwcm_pkg::SVC_ARM);
      wb(1'b1, rwcm_pkg::IDX_SERVICE, 8'h12);
      wb(1'b1, rwcm_pkg::IDX_SERVICE, rwcm_pkg::SVC_CLEAR);
      wait_rst(n);
      `CHK(n > lim - 8 && n < lim + 8, 1'b1)
      rchk(rwcm_pkg::IDX_CAUSE, 8'h07, 8'h02);
    end
  endtask

  task automatic t_config;
    wb(1'b1, rwcm_pkg::IDX_CONFIG, 8'h01);
    rchk(rwcm_pkg::IDX_CONFIG, 8'h03, 8'h01);
    wb(1'b1, rwcm_pkg::IDX_CONFIG, 8'h02);
    rchk(rwcm_pkg::IDX_CONFIG, 8'h03, 8'h01);
    repeat (600) @(posedge CLK);
    `CHK(sys_rst_n, 1'b1)
    wb(1'b1, rwcm_pkg::IDX_OPTIONS, 8'h03);
    rchk(rwcm_pkg::IDX_OPTIONS, 8'h03, 8'h00);
  endtask

  task automatic t_monitor;
    wb(1'b1, rwcm_pkg::IDX_OPTIONS, 8'h08);
    rchk(rwcm_pkg::IDX_OPTIONS, 8'h0c, 8'h08);
    repeat (100) @(posedge CLK);
    `CHK(sys_rst_n, 1'b1)
    mon_run <= 1'b0;
    wait_rst(n);
    mon_run <= 1'b1;
    `CHK(n < CML + 12, 1'b1)
    rchk(rwcm_pkg::IDX_CAUSE, 8'h07, 8'h04);
    rchk(rwcm_pkg::IDX_OPTIONS, 8'h0c, 8'h00);
    wb(1'b1, rwcm_pkg::IDX_OPTIONS, 8'h04);
    wb(1'b1, rwcm_pkg::IDX_OPTIONS, 8'h00);
    rchk(rwcm_pkg::IDX_OPTIONS, 8'h0c, 8'h04);
    mon_run <= 1'b0;
    wait_rst(n);
    mon_run <= 1'b1;
    `CHK(n < CML + 12, 1'b1)
  endtask

  // Internal trip with the pin held past release, then a plain external reset
  task automatic t_external;
    hold_len <= 8'h28;
    wb(1'b1, rwcm_pkg::IDX_OPTIONS, 8'h08);
    mon_run <= 1'b0;
    wait_rst(n);
    mon_run <= 1'b1;
    hold_len <= 8'h00;
    rchk(rwcm_pkg::IDX_CAUSE, 8'h07, 8'h01);
    ext_pull <= 1'b1;
    repeat (20) @(posedge CLK);
    `CHK({sys_rst_n, pin_oe}, 2'b00)
    ext_pull <= 1'b0;
    wait_rst(n);
    rchk(rwcm_pkg::IDX_CAUSE, 8'h07, 8'h01);
  endtask

  // Special expanded straps, taken again at an external reset
  task automatic t_pins;
    mode_sp  <= 1'b1;
    mode_ex  <= 1'b1;
    ext_pull <= 1'b1;
    repeat (8) @(posedge CLK);
    ext_pull <= 1'b0;
    wait_rst(n);
    rchk(rwcm_pkg::IDX_OPTIONS2, 8'h07, 8'h04);
    rchk(rwcm_pkg::IDX_TEST, 8'h01, 8'h01);
    wb(1'b1, rwcm_pkg::IDX_TEST, 8'h00);
    rchk(rwcm_pkg::IDX_TEST, 8'h01, 8'h00);
    wb(1'b1, rwcm_pkg::IDX_CONFIG, 8'h03);
    wb(1'b1, rwcm_pkg::IDX_CONFIG, 8'h01);
    rchk(rwcm_pkg::IDX_CONFIG, 8'h03, 8'h01);
    wb(1'b1, rwcm_pkg::IDX_OPTIONS2, 8'h01);
    repeat (3) @(posedge CLK);
    `CHK(pc_oe, 8'hf0)
    wb(1'b1, rwcm_pkg::IDX_OPTIONS2, 8'h02);
    repeat (3) @(posedge CLK);
    `CHK(pc_oe, 8'hff)
    pulse_acc(1'b0, 1'b1);
    pulse_acc(1'b1, 1'b0);
    wb(1'b1, rwcm_pkg::IDX_OPTIONS2, 8'h00);
    pulse_acc(1'b0, 1'b0);
    @(posedge CLK);
    instr_start <= 1'b1;
    @(posedge CLK);
    instr_start <= 1'b0;
    #1;
    `CHK(lir_o, 1'b0)
    repeat (3) @(posedge CLK);
    instr_start <= 1'b1;
    repeat (2) @(posedge CLK);
    instr_start <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #800000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    RSTN = 1'b0;
    wb_req = '0;
    {mon_clk, instr_start, ext_acc, ext_hi, ext_pull, mode_sp, mode_ex} = 7'h00;
    mon_run = 1'b1;
    mcnt = 2'h0;
    hold_len = 8'h00;
    pc_data = 8'h0f;
    pc_dir = 8'hff;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (8) @(posedge CLK);
    t_reset_values();
    t_watchdog();
    t_config();
    t_monitor();
    t_external();
    t_pins();
    end_sim();
  end
endmodule

`default_nettype wire
